// file: l1_data_cache_snoop_write.v
// first-level data cache: indexing, two-way replacement, snoop-write queue
// Contract
// - storage is in 64-byte lines; a snoop write updates only the addressed word of its line
// - set index is bits 6 up to 10/11/12/13 by size; 0 KB means no cache
// - at 32 KB, same set exactly when bits 13:6 are equal
// - each set has two ways; full set allocation replaces a resident line
// - second_level_memory forwards non-CPU writes as snoop-write requests
// - every non-CPU master counts as a snoop-write source
// - snoop-writes run one at a time; a later one waits
// - a pending snoop-write whose line was replaced is cancelled
// - clean victim is overwritten; dirty victim is evicted first
// - two same-cycle CPU reads may each miss, request and allocate
// - a CPU-modified line is written back with current contents
`timescale 1ns/10ps
`default_nettype none
`include "l1d_snoop_consts.vh"
module l1_data_cache_snoop_write (
  // clock and reset
  input wire CLK_SYS,
  input wire RST_N,
  // configuration
  input wire [2:0] CACHE_SIZE,
  // cpu read ports 0 and 1
  input wire RD0_VALID,
  input wire [31:0] RD0_ADDR,
  input wire RD1_VALID,
  input wire [31:0] RD1_ADDR,
  output wire RD_READY,
  output reg RD0_HIT,
  output reg RD1_HIT,
  output reg [31:0] RD0_DATA,
  output reg [31:0] RD1_DATA,
  // cpu write port (hits only)
  input wire WR_VALID,
  input wire [31:0] WR_ADDR,
  input wire [31:0] WR_DATA,
  // line fill requests to second_level_memory, one per read port
  output reg FILL0_REQ,
  output reg [31:0] FILL0_ADDR,
  output reg FILL1_REQ,
  output reg [31:0] FILL1_ADDR,
  // line fill returns, one word per beat, word index in order 0..15
  input wire FILL0_VALID,
  input wire [31:0] FILL0_DATA,
  input wire FILL1_VALID,
  input wire [31:0] FILL1_DATA,
  // victim write-back
  output reg VIC_VALID,
  output reg [31:0] VIC_ADDR,
  output reg [31:0] VIC_DATA,
  output reg VIC_LAST,
  // snoop-write requests from second_level_memory
  input wire SNP_VALID,
  input wire [31:0] SNP_ADDR,
  input wire [31:0] SNP_DATA,
  output wire SNP_READY,
  output reg SNP_DONE,
  output reg SNP_DROPPED
);
  localparam ST_IDLE = 2'h0;
  localparam ST_EVICT = 2'h1;
  localparam ST_FILL = 2'h2;
  localparam NSETS = 256;

  // -------------------------------------------------------------
  // storage
  // -------------------------------------------------------------
  reg [31:0] data_mem [0:2*NSETS*`LINE_WORDS-1];
  reg [2*NSETS-1:0] valid_ff;
  reg [2*NSETS-1:0] dirty_ff;
  reg [NSETS-1:0] lru_ff;
  integer i;
  // snoop slot state, declared early because the index and read gating use it
  reg snp_pend_ff;
  reg [31:0] snp_addr_ff;
  reg [31:0] snp_data_ff;
  reg snp_kill_ff;
  wire snp_issue;

  wire [7:0] set0, set1, setw, sets;
  wire on0, on1, onw, ons;
  set_index_sel u_idx0 (.addr(RD0_ADDR), .cache_size(CACHE_SIZE), .set_idx(set0), .cache_on(on0));
  set_index_sel u_idx1 (.addr(RD1_ADDR), .cache_size(CACHE_SIZE), .set_idx(set1), .cache_on(on1));
  set_index_sel u_idxw (.addr(WR_ADDR), .cache_size(CACHE_SIZE), .set_idx(setw), .cache_on(onw));
  set_index_sel u_idxs (.addr(snp_addr_ff), .cache_size(CACHE_SIZE), .set_idx(sets),
    .cache_on(ons));

  // -------------------------------------------------------------
  // lookup
  // -------------------------------------------------------------
  // full line address compare, so smaller sizes alias safely
  reg [25:0] line_mem [0:2*NSETS-1];
  function hit_way;
    input [25:0] la;
    input v;
    input [25:0] stored;
    begin
      hit_way = v && (stored == la);
    end
  endfunction

  wire h0w0 = on0 && hit_way(RD0_ADDR[31:6], valid_ff[{set0, 1'b0}], line_mem[{set0, 1'b0}]);
  wire h0w1 = on0 && hit_way(RD0_ADDR[31:6], valid_ff[{set0, 1'b1}], line_mem[{set0, 1'b1}]);
  wire h1w0 = on1 && hit_way(RD1_ADDR[31:6], valid_ff[{set1, 1'b0}], line_mem[{set1, 1'b0}]);
  wire h1w1 = on1 && hit_way(RD1_ADDR[31:6], valid_ff[{set1, 1'b1}], line_mem[{set1, 1'b1}]);
  wire hww0 = onw && hit_way(WR_ADDR[31:6], valid_ff[{setw, 1'b0}], line_mem[{setw, 1'b0}]);
  wire hww1 = onw && hit_way(WR_ADDR[31:6], valid_ff[{setw, 1'b1}], line_mem[{setw, 1'b1}]);

  // -------------------------------------------------------------
  // miss engines, one per read port
  // -------------------------------------------------------------
  reg [1:0] st_ff [0:1];
  reg [31:0] miss_addr_ff [0:1];
  reg [8:0] miss_loc_ff [0:1];
  reg [3:0] beat_ff [0:1];
  // one victim channel shared; port 0 has priority
  wire busy = (st_ff[0] != ST_IDLE) || (st_ff[1] != ST_IDLE);
  assign RD_READY = !busy;
  wire take = RD_READY && !snp_issue;
  wire miss0 = take && RD0_VALID && on0 && !h0w0 && !h0w1;
  wire miss1 = take && RD1_VALID && on1 && !h1w0 && !h1w1;
  // same line on both ports: only port 0 allocates
  wire same_line = RD0_ADDR[31:6] == RD1_ADDR[31:6];
  wire miss1_eff = miss1 && !(miss0 && same_line);
  // victim choice: empty way first, else the way least recently hit by port 0, written or filled
  wire [8:0] loc0 = {set0, !valid_ff[{set0, 1'b0}] ? 1'b0 :
    !valid_ff[{set0, 1'b1}] ? 1'b1 : lru_ff[set0]};
  wire [8:0] loc1_raw = {set1, !valid_ff[{set1, 1'b0}] ? 1'b0 :
    !valid_ff[{set1, 1'b1}] ? 1'b1 : lru_ff[set1]};
  // same set on both ports: second allocation goes to the other way
  wire [8:0] loc1 = (miss0 && set0 == set1) ? {set1, !loc0[0]} : loc1_raw;

  // victim write-back runs for one engine at a time
  reg vic_own_ff;
  reg [3:0] vic_beat_ff;
  wire ev0 = st_ff[0] == ST_EVICT;
  wire ev1 = st_ff[1] == ST_EVICT && !ev0;
  wire [8:0] vloc = ev0 ? miss_loc_ff[0] : miss_loc_ff[1];
  // replacement start flags, compared by set to cancel a waiting snoop-write
  wire repl0 = miss0;
  wire repl1 = miss1_eff;

  // -------------------------------------------------------------
  // snoop-write slot: one in service, later ones stalled
  // -------------------------------------------------------------
  assign SNP_READY = !snp_pend_ff;
  assign snp_issue = snp_pend_ff && !busy;
  wire [8:0] snp_hit_loc = {sets, line_mem[{sets, 1'b1}] == snp_addr_ff[31:6]
    && valid_ff[{sets, 1'b1}]};
  wire snp_hit = ons && ((valid_ff[{sets, 1'b0}] && line_mem[{sets, 1'b0}] == snp_addr_ff[31:6])
    || snp_hit_loc[0]);

  // -------------------------------------------------------------
  // sequential state
  // -------------------------------------------------------------
  always @(posedge CLK_SYS) begin
    if (!RST_N) begin
      valid_ff <= {2*NSETS{1'b0}};
      dirty_ff <= {2*NSETS{1'b0}};
      lru_ff <= {NSETS{1'b0}};
      st_ff[0] <= ST_IDLE;
      st_ff[1] <= ST_IDLE;
      beat_ff[0] <= 4'h0;
      beat_ff[1] <= 4'h0;
      miss_addr_ff[0] <= 32'h0;
      miss_addr_ff[1] <= 32'h0;
      miss_loc_ff[0] <= 9'h000;
      miss_loc_ff[1] <= 9'h000;
      vic_beat_ff <= 4'h0;
      vic_own_ff <= 1'b0;
      snp_pend_ff <= 1'b0;
      snp_addr_ff <= 32'h0;
      snp_data_ff <= 32'h0;
      snp_kill_ff <= 1'b0;
      RD0_HIT <= 1'b0;
      RD1_HIT <= 1'b0;
      RD0_DATA <= 32'h0;
      RD1_DATA <= 32'h0;
      FILL0_REQ <= 1'b0;
      FILL1_REQ <= 1'b0;
      FILL0_ADDR <= 32'h0;
      FILL1_ADDR <= 32'h0;
      VIC_VALID <= 1'b0;
      VIC_ADDR <= 32'h0;
      VIC_DATA <= 32'h0;
      VIC_LAST <= 1'b0;
      SNP_DONE <= 1'b0;
      SNP_DROPPED <= 1'b0;
    end else begin
      FILL0_REQ <= 1'b0;
      FILL1_REQ <= 1'b0;
      VIC_VALID <= 1'b0;
      VIC_LAST <= 1'b0;
      SNP_DONE <= 1'b0;
      SNP_DROPPED <= 1'b0;
      RD0_HIT <= take && RD0_VALID && (h0w0 || h0w1);
      RD1_HIT <= take && RD1_VALID && (h1w0 || h1w1);
      RD0_DATA <= data_mem[{set0, h0w1, RD0_ADDR[5:2]}];
      RD1_DATA <= data_mem[{set1, h1w1, RD1_ADDR[5:2]}];
      // cpu write hit marks line dirty
      if (WR_VALID && (hww0 || hww1)) begin
        data_mem[{setw, hww1, WR_ADDR[5:2]}] <= WR_DATA;
        dirty_ff[{setw, hww1}] <= 1'b1;
        lru_ff[setw] <= !hww1;
      end
      // port 0 read hits update recency
      if (take && RD0_VALID && (h0w0 || h0w1))
        lru_ff[set0] <= !h0w1;
      // start of misses: line leaves, dirty one goes to eviction first
      if (miss0) begin
        st_ff[0] <= dirty_ff[loc0] && valid_ff[loc0] ? ST_EVICT : ST_FILL;
        if (!(dirty_ff[loc0] && valid_ff[loc0])) valid_ff[loc0] <= 1'b0;
        miss_addr_ff[0] <= {RD0_ADDR[31:6], 6'h00};
        miss_loc_ff[0] <= loc0;
        beat_ff[0] <= 4'h0;
        lru_ff[set0] <= !loc0[0];
        FILL0_REQ <= 1'b1;
        FILL0_ADDR <= {RD0_ADDR[31:6], 6'h00};
      end
      if (miss1_eff) begin
        st_ff[1] <= dirty_ff[loc1] && valid_ff[loc1] ? ST_EVICT : ST_FILL;
        if (!(dirty_ff[loc1] && valid_ff[loc1])) valid_ff[loc1] <= 1'b0;
        miss_addr_ff[1] <= {RD1_ADDR[31:6], 6'h00};
        miss_loc_ff[1] <= loc1;
        beat_ff[1] <= 4'h0;
        lru_ff[set1] <= !loc1[0];
        FILL1_REQ <= 1'b1;
        FILL1_ADDR <= {RD1_ADDR[31:6], 6'h00};
      end
      // victim stream: 16 words, then the line is freed for the fill
      if (ev0 || ev1) begin
        VIC_VALID <= 1'b1;
        VIC_ADDR <= {line_mem[vloc], 6'h00};
        VIC_DATA <= data_mem[{vloc, vic_beat_ff}];
        VIC_LAST <= vic_beat_ff == 4'hF;
        vic_beat_ff <= vic_beat_ff + 4'h1;
        if (vic_beat_ff == 4'hF) begin
          valid_ff[vloc] <= 1'b0;
          dirty_ff[vloc] <= 1'b0;
          if (ev0) st_ff[0] <= ST_FILL;
          else st_ff[1] <= ST_FILL;
        end
      end
      // fills complete the allocation
      for (i = 0; i < 2; i = i + 1) begin
        if (st_ff[i] == ST_FILL && (i == 0 ? FILL0_VALID : FILL1_VALID)) begin
          data_mem[{miss_loc_ff[i], beat_ff[i]}] <= i == 0 ? FILL0_DATA : FILL1_DATA;
          beat_ff[i] <= beat_ff[i] + 4'h1;
          if (beat_ff[i] == 4'hF) begin
            line_mem[miss_loc_ff[i]] <= miss_addr_ff[i][31:6];
            valid_ff[miss_loc_ff[i]] <= 1'b1;
            dirty_ff[miss_loc_ff[i]] <= 1'b0;
            st_ff[i] <= ST_IDLE;
          end
        end
      end
      // accept a snoop-write from any non-cpu master
      if (SNP_VALID && SNP_READY) begin
        snp_pend_ff <= 1'b1;
        snp_addr_ff <= SNP_ADDR;
        snp_data_ff <= SNP_DATA;
        snp_kill_ff <= 1'b0;
      end
      // replacement of the target set kills the waiting snoop-write
      if (snp_pend_ff && ((repl0 && set0 == sets) || (repl1 && set1 == sets)))
        snp_kill_ff <= 1'b1;
      // issue: hit and not killed updates the addressed word of the line, else drop
      if (snp_issue) begin
        snp_pend_ff <= 1'b0;
        SNP_DONE <= 1'b1;
        if (snp_hit && !snp_kill_ff)
          data_mem[{snp_hit_loc, snp_addr_ff[5:2]}] <= snp_data_ff;
        else
          SNP_DROPPED <= 1'b1;
      end
    end
  end
endmodule // l1_data_cache_snoop_write
`default_nettype wire

// file: l1d_snoop_consts.vh
// constants for the first-level data cache with snoop-write handling
`ifndef L1D_SNOOP_CONSTS_VH
`define L1D_SNOOP_CONSTS_VH
`define ADDR_W 32
`define LINE_LSB 6
`define WORD_W 32
`define LINE_WORDS 16
`define WORD_SEL_W 4
`define SET_MAX_W 8
`define SET_MSB_4K 10
`define SET_MSB_8K 11
`define SET_MSB_16K 12
`define SET_MSB_32K 13
`define SIZE_0K 3'h0
`define SIZE_4K 3'h1
`define SIZE_8K 3'h2
`define SIZE_16K 3'h3
`define SIZE_32K 3'h4
`define SET_MASK_4K 8'h1F
`define SET_MASK_8K 8'h3F
`define SET_MASK_16K 8'h7F
`define SET_MASK_32K 8'hFF
`define SET_MASK_0K 8'h00
`endif

// file: set_index_sel.v
// set index extraction for one address, by configured cache size
`timescale 1ns/10ps
`default_nettype none
`include "l1d_snoop_consts.vh"
module set_index_sel (
  // address and size
  input wire [31:0] addr,
  input wire [2:0] cache_size,
  // result
  output reg [7:0] set_idx,
  output reg cache_on
);
  // -------------------------------------------------------------
  // index select
  // -------------------------------------------------------------
  // keep bits from 6 up to the size-selected upper bit
  always @* begin
    cache_on = 1'b1;
    case (cache_size)
      `SIZE_4K: set_idx = addr[`SET_MSB_32K:`LINE_LSB] & `SET_MASK_4K;
      `SIZE_8K: set_idx = addr[`SET_MSB_32K:`LINE_LSB] & `SET_MASK_8K;
      `SIZE_16K: set_idx = addr[`SET_MSB_32K:`LINE_LSB] & `SET_MASK_16K;
      `SIZE_32K: set_idx = addr[`SET_MSB_32K:`LINE_LSB] & `SET_MASK_32K;
      default: begin
        set_idx = `SET_MASK_0K;
        cache_on = 1'b0;
      end
    endcase
  end
endmodule // set_index_sel
`default_nettype wire

// file: l1d_snoop_chk.sv
// port checker for the data cache with snoop-write queue
`timescale 1ns/10ps
`default_nettype none
module l1d_snoop_chk (
  // clock, reset, size
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [2:0] CACHE_SIZE,
  // reads and fills
  input wire logic RD0_VALID,
  input wire logic RD1_VALID,
  input wire logic RD_READY,
  input wire logic RD0_HIT,
  input wire logic FILL0_REQ,
  input wire logic [31:0] FILL0_ADDR,
  input wire logic FILL1_REQ,
  // victims and snoops
  input wire logic VIC_VALID,
  input wire logic [31:0] VIC_ADDR,
  input wire logic VIC_LAST,
  input wire logic SNP_VALID,
  input wire logic SNP_READY,
  input wire logic SNP_DONE,
  input wire logic SNP_DROPPED
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  a_hit_needs_read: assert property (RD0_HIT |-> $past(RD0_VALID && RD_READY)
    && $past(CACHE_SIZE) inside {[1:4]}) else $error("hit without accepted read");
  a_fill0_cause: assert property (FILL0_REQ |-> $past(RD0_VALID && RD_READY)
    && FILL0_ADDR[5:0] == 6'h00) else $error("bad fill request on port 0");
  a_fill1_cause: assert property (FILL1_REQ |-> $past(RD1_VALID && RD_READY))
    else $error("bad fill request on port 1");
  a_miss_busy: assert property (FILL0_REQ || FILL1_REQ |-> !RD_READY)
    else $error("reads open while a miss is busy");
  a_drop_with_done: assert property (SNP_DROPPED |-> SNP_DONE)
    else $error("drop flag without done");
  a_snoop_single: assert property (SNP_VALID && SNP_READY |=> !SNP_READY)
    else $error("second snoop open while one pending");
  a_done_pending: assert property (SNP_DONE |-> $past(!SNP_READY) && $past(RD_READY))
    else $error("snoop issued without pending or during miss");
  a_victim_burst: assert property (VIC_LAST |-> VIC_VALID && $past(VIC_VALID, 15)
    && (!$past(VIC_VALID, 16) || $past(VIC_LAST, 16))) else $error("victim burst not sixteen beats");
  a_victim_addr: assert property (VIC_VALID && !VIC_LAST |=> VIC_VALID
    && $stable(VIC_ADDR) && VIC_ADDR[5:0] == 6'h00) else $error("victim burst broken");
  a_victim_on_miss: assert property ($rose(VIC_VALID) |-> $past(FILL0_REQ || FILL1_REQ))
    else $error("victim without a miss");
endmodule // l1d_snoop_chk
bind l1_data_cache_snoop_write l1d_snoop_chk u_l1d_snoop_chk (.CLK_SYS, .RST_N, .CACHE_SIZE,
  .RD0_VALID, .RD1_VALID, .RD_READY, .RD0_HIT, .FILL0_REQ, .FILL0_ADDR, .FILL1_REQ,
  .VIC_VALID, .VIC_ADDR, .VIC_LAST, .SNP_VALID, .SNP_READY, .SNP_DONE, .SNP_DROPPED);
`default_nettype wire

// file: l2_fill_model.sv
// second_level_memory model answering line fills
`timescale 1ns/10ps
`default_nettype none
module l2_fill_model #(parameter int DLY = 2) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request and victim activity
  input wire logic req,
  input wire logic [31:0] addr,
  input wire logic hold,
  // fill beats
  output logic valid,
  output logic [31:0] data
);
  logic [31:0] base_ff;
  int wait_ff;
  int beat_ff;
  // wait, let a victim burst pass, then 16 beats word 0 first; idle bus toggles
  always @(posedge clk) begin
    valid <= 1'b0;
    data <= ~data;
    if (!rst_n) begin
      data <= 32'h0;
      beat_ff <= 16;
      wait_ff <= 0;
    end else if (req) begin
      base_ff <= addr;
      beat_ff <= 0;
      wait_ff <= DLY;
    end else if (wait_ff > 0) begin
      wait_ff <= wait_ff - 1;
    end else if (beat_ff < 16 && !hold) begin
      valid <= 1'b1;
      data <= base_ff + 32'(beat_ff * 4);
      beat_ff <= beat_ff + 1;
    end
  end
endmodule // l2_fill_model
`default_nettype wire

// file: tb_l1_data_cache_snoop_write.sv
// self-checking bench for the data cache with snoop-write queue
`timescale 1ns/10ps
`default_nettype none
module tb_l1_data_cache_snoop_write;
  logic CLK_SYS = 1'b0;
  logic RST_N = 1'b0;
  logic [2:0] CACHE_SIZE = 3'h4;
  logic RD0_VALID = 1'b0, RD1_VALID = 1'b0, WR_VALID = 1'b0, SNP_VALID = 1'b0;
  logic [31:0] RD0_ADDR = 32'h0, RD1_ADDR = 32'h0, WR_ADDR = 32'h0, WR_DATA = 32'h0;
  logic [31:0] SNP_ADDR = 32'h0, SNP_DATA = 32'h0, vic_w;
  wire RD_READY, RD0_HIT, RD1_HIT, FILL0_REQ, FILL1_REQ, FILL0_VALID, FILL1_VALID;
  wire VIC_VALID, VIC_LAST, SNP_READY, SNP_DONE, SNP_DROPPED;
  wire [31:0] RD0_DATA, RD1_DATA, FILL0_ADDR, FILL1_ADDR, FILL0_DATA, FILL1_DATA;
  wire [31:0] VIC_ADDR, VIC_DATA;
  int n_fail = 0, comparisons = 0, cycles = 0, vic_n = 0;
  l1_data_cache_snoop_write u_l1_data_cache_snoop_write (.CLK_SYS, .RST_N, .CACHE_SIZE,
    .RD0_VALID, .RD0_ADDR, .RD1_VALID, .RD1_ADDR, .RD_READY, .RD0_HIT, .RD1_HIT,
    .RD0_DATA, .RD1_DATA, .WR_VALID, .WR_ADDR, .WR_DATA, .FILL0_REQ, .FILL0_ADDR,
    .FILL1_REQ, .FILL1_ADDR, .FILL0_VALID, .FILL0_DATA, .FILL1_VALID, .FILL1_DATA,
    .VIC_VALID, .VIC_ADDR, .VIC_DATA, .VIC_LAST, .SNP_VALID, .SNP_ADDR, .SNP_DATA,
    .SNP_READY, .SNP_DONE, .SNP_DROPPED);
  l2_fill_model #(.DLY(2)) u_l2_fill_model_0 (.clk(CLK_SYS), .rst_n(RST_N), .req(FILL0_REQ),
    .addr(FILL0_ADDR), .hold(VIC_VALID), .valid(FILL0_VALID), .data(FILL0_DATA));
  l2_fill_model #(.DLY(6)) u_l2_fill_model_1 (.clk(CLK_SYS), .rst_n(RST_N), .req(FILL1_REQ),
    .addr(FILL1_ADDR), .hold(VIC_VALID), .valid(FILL1_VALID), .data(FILL1_DATA));
  // 40 MHz clock
  always #12.5 CLK_SYS = ~CLK_SYS;
  // victim beat counter, word 3 capture, run limit
  always @(posedge CLK_SYS) begin
    cycles <= cycles + 1;
    if (VIC_VALID && vic_n == 3) vic_w <= VIC_DATA;
    if (VIC_VALID) vic_n <= vic_n + 1;
    if (cycles == 30000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge CLK_SYS);
    #2;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic rst(input logic [2:0] sz);
    RST_N = 1'b0;
    CACHE_SIZE = sz;
    vic_n = 0;
    tick(16);
    RST_N = 1'b1;
  endtask
  task automatic rd(input logic [31:0] a0, input logic v1, input logic [31:0] a1);
    int i;
    for (i = 0; i < 200 && RD_READY !== 1'b1; i++) tick();
    {RD0_VALID, RD0_ADDR, RD1_VALID, RD1_ADDR} = {1'b1, a0, v1, a1};
    tick();
    {RD0_VALID, RD0_ADDR, RD1_VALID, RD1_ADDR} = {1'b0, ~a0, 1'b0, ~a1};
  endtask
  task automatic hit(input logic [31:0] a, input logic h, input logic [31:0] d);
    rd(a, 1'b0, 32'h0);
    check({31'h0, RD0_HIT}, {31'h0, h}, "hit flag");
    if (h) check(RD0_DATA, d, "read data");
  endtask
  task automatic load(input logic [31:0] a);
    rd(a, 1'b0, 32'h0);
    check({31'h0, FILL0_REQ}, 32'h1, "fill request");
    check(FILL0_ADDR, {a[31:6], 6'h00}, "fill address");
  endtask
  task automatic snp(input logic [31:0] a, input logic [31:0] d, input logic drop);
    int i;
    for (i = 0; i < 200 && SNP_READY !== 1'b1; i++) tick();
    {SNP_VALID, SNP_ADDR, SNP_DATA} = {1'b1, a, d};
    tick();
    {SNP_VALID, SNP_ADDR, SNP_DATA} = {1'b0, ~a, ~d};
    check({31'h0, SNP_READY}, 32'h0, "snoop ready after accept");
    for (i = 0; i < 200 && SNP_DONE !== 1'b1; i++) tick();
    check({31'h0, SNP_DROPPED}, {31'h0, drop}, "snoop drop flag");
  endtask
  // per size: a third line in a set evicts the oldest, a line one bit lower stays
  task automatic s_sets;
    logic [31:0] a, s;
    for (int sz = 1; sz <= 4; sz++) begin
      rst(sz[2:0]);
      a = 32'h0000_1244;
      s = 32'h1 << (sz + 10);
      load(a);
      load(a + (s >> 1));
      load(a + s);
      load(a + 2 * s);
      hit(a, 1'b0, 32'h0);
      hit(a + (s >> 1), 1'b1, a + (s >> 1));
      check(vic_n, 32'h0, "clean line sent as victim");
    end
  endtask
  // two reads in one cycle both miss, fill and then hit
  task automatic s_dual;
    rst(3'h4);
    rd(32'h0000_0104, 1'b1, 32'h0000_02C8);
    check({30'h0, FILL0_REQ, FILL1_REQ}, 32'h3, "dual fill requests");
    check(FILL1_ADDR, 32'h0000_02C0, "port 1 fill address");
    rd(32'h0000_0104, 1'b1, 32'h0000_02C8);
    check({30'h0, RD0_HIT, RD1_HIT}, 32'h3, "dual hits");
    check(RD1_DATA, 32'h0000_02C8, "port 1 data");
  endtask
  // written line evicted with its new contents
  task automatic s_dirty;
    int i;
    rst(3'h4);
    load(32'h0000_0300);
    for (i = 0; i < 200 && RD_READY !== 1'b1; i++) tick();
    {WR_VALID, WR_ADDR, WR_DATA} = {1'b1, 32'h0000_030C, 32'hA5A5_0003};
    tick();
    {WR_VALID, WR_ADDR, WR_DATA} = {1'b0, 32'hFFFF_FCF3, 32'h5A5A_FFFC};
    load(32'h0000_4300);
    load(32'h0000_8300);
    hit(32'h0000_8300, 1'b1, 32'h0000_8300);
    check(vic_n, 32'h10, "victim beat count");
    check(vic_w, 32'hA5A5_0003, "victim data");
  endtask
  // snoop hit at an unaligned address mid-line, snoop miss, snoop to a replaced line
  task automatic s_snoop;
    rst(3'h4);
    load(32'h0000_0500);
    snp(32'h0000_0537, 32'h1234_ABCD, 1'b0);
    hit(32'h0000_0534, 1'b1, 32'h1234_ABCD);
    snp(32'h0001_0500, 32'h0BAD_0BAD, 1'b1);
    snp(32'h0001_0540, 32'h0BAD_0BAD, 1'b1);
    load(32'h0000_0700);
    load(32'h0000_4700);
    rd(32'h0000_8700, 1'b0, 32'h0);
    snp(32'h0000_0704, 32'hDEAD_0001, 1'b1);
    hit(32'h0000_8704, 1'b1, 32'h0000_8704);
  endtask
  initial begin
    s_sets();
    s_dual();
    s_dirty();
    s_snoop();
    print_verdict();
  end
endmodule // tb_l1_data_cache_snoop_write
`default_nettype wire
